// file: imdec_pkg.sv
// package of the image memory instruction decoder: fields, offsets, types
package imdec_pkg;
    // instruction field positions, first dword
    localparam int OP_LO_POS    = 0;
    localparam int NSA_LO_POS   = 1;
    localparam int DEVCOH_POS   = 7;
    localparam int DMASK_LO_POS = 8;
    localparam int UNNORMALIZED_ADDR_BIT_POS     = 12;
    localparam int GLC_POS      = 13;
    localparam int SMALL_POS    = 15;
    localparam int TFE_POS      = 16;
    localparam int LWE_POS      = 17;
    localparam int OP_HI_LO_POS = 18;
    localparam int SYSCOH_POS   = 25;
    localparam int ENC_LO_POS   = 26;
    // second dword fields, positions within dword 1
    localparam int ADDR_VREG_FIELD_LO_POS = 0;
    localparam int DATA_VREG_FIELD_LO_POS = 8;
    localparam int RSRC_LO_POS  = 16;
    localparam int SAMP_LO_POS  = 21;
    localparam int HADDR_POS    = 30;
    localparam int HDATA_POS    = 31;
    // major encoding of the image memory format
    localparam logic [5:0] IMG_ENCODING = 6'h3c;
    // instruction length limits in dwords
    localparam logic [2:0] MIN_DWORDS   = 3'h2;
    localparam logic [2:0] MAX_DWORDS   = 3'h5;
    // scalar register counts of the resource constant
    localparam logic [3:0] SMALL_RSRC_REGS = 4'h4;
    localparam logic [3:0] LARGE_RSRC_REGS = 4'h8;
    // opcodes of the load and store entries
    localparam logic [7:0] OPC_LOAD       = 8'h00;
    localparam logic [7:0] OPC_LOAD_MIP   = 8'h01;
    localparam logic [7:0] OPC_STORE      = 8'h08;
    localparam logic [7:0] OPC_STORE_MIP  = 8'h09;
    // atomic opcode window, values are arbitrary defaults
    localparam logic [7:0] OPC_ATOMIC_LO  = 8'h0f;
    localparam logic [7:0] OPC_ATOMIC_HI  = 8'h1f;
    // address slots: one base plus four per extra dword
    localparam int ADDR_SLOTS = 13;
    // register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT  = 4'h8;
    localparam logic [3:0] REG_LAST   = 4'hc;
    // reset value and bus transfer type
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // operation class of the decoded opcode
    typedef enum logic [2:0] {
        IMDEC_LOAD, IMDEC_LOAD_LVL, IMDEC_STORE, IMDEC_STORE_LVL,
        IMDEC_ATOMIC, IMDEC_OTHER
    } imdec_op_t;

    // decoded instruction handed to the memory pipeline
    typedef struct packed {
        imdec_op_t       op_class;
        logic [7:0]      opcode;
        logic [2:0]      length;
        logic [1:0]      nsa_cnt;
        logic            dev_coh;
        logic [3:0]      dmask;
        logic            unnorm;
        logic            l0_bypass;
        logic            return_preop;
        logic            small_rsrc;
        logic [3:0]      rsrc_cnt;
        logic            tex_fail_en;
        logic            lod_warn_en;
        logic [1:0]      l2_policy;
        logic [7:0]      data_vreg;
        logic [6:0]      rsrc_sreg;
        logic [6:0]      samp_sreg;
        logic            half_addr;
        logic            addr_float;
        logic            half_data;
        logic [2:0]      data_reg_cnt;
        logic [3:0][7:0] comp_vreg;
        logic [3:0]      comp_half;
        logic [3:0]      comp_zero;
        logic [ADDR_SLOTS-1:0][7:0] addr_vreg;
    } imdec_dec_t;
endpackage

// file: imdec_top.sv
// image memory instruction decoder with its register slave
// What this block does
// - accept 2 to 5 dwords, consume exactly
// - normal form uses contiguous address registers
// - scattered form reads 1-3 extra register dwords
// - bits 2:1 count extra dwords
// - bit 7 marks device coherent access
// - mask picks returned components, consecutive registers
// - store components not enabled written zero
// - half data stores use mask as count
// - bit 12 unnormalized, required on stores
// - bit 13 bypass, or atomic returns old
// - bit 15 picks four or eight registers
// - bit 16 passes texture fail enable
// - bit 17 allows lod clamp warning
// - opcode from bit 0 and 24:18
// - bit 25 with bit 7 sets l2 policy
// - bits 39:32 first address register
// - bits 47:40 first data register
// - bits 52:48 resource pointer, four aligned
// - bits 57:53 sampler pointer, four aligned
// - bit 62 packs address components half width
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module imdec_top (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // ahb-lite register slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // instruction dwords from fetch
    input  wire logic [31:0]          fetch_dword,
    input  wire logic                 fetch_valid,
    output logic                      fetch_ready,
    // decoded instruction to the memory pipeline
    output var imdec_pkg::imdec_dec_t dec_out,
    output logic                      dec_valid,
    input  wire logic                 dec_ready
);
    import imdec_pkg::*;

    // decode sequence states
    typedef enum logic [2:0] {S_DW0, S_DW1, S_EXT, S_DEC, S_OUT} imdec_st_t;

    imdec_st_t        st_ff, nxt_st;     // sequence state
    logic [31:0]      dw0_ff;            // first dword
    logic [31:0]      dw1_ff;            // second dword
    logic [2:0][31:0] ext_ff;            // extra address dwords
    logic [1:0]       ext_idx_ff;        // extra dwords taken
    imdec_dec_t       dec_ff;            // registered decode
    imdec_dec_t       dec_w;             // decode of held dwords
    logic             en_ff;             // decoder enable
    logic             bad_enc_ff;        // sticky wrong encoding
    logic             unnormalized_addr_bit_err_ff;       // sticky missing unnorm on store
    logic [15:0]      count_ff;          // decoded instruction count
    logic             wr_pend_ff;        // ahb write data phase
    logic [3:0]       wr_addr_ff;        // ahb write offset
    logic             rd_pend_ff;        // ahb read data phase
    logic [3:0]       rd_addr_ff;        // ahb read offset

    // handshakes
    wire take_w    = fetch_valid & fetch_ready;
    wire enc_ok_w  = fetch_dword[31:ENC_LO_POS] == IMG_ENCODING;
    wire [1:0] nsa_w = dw0_ff[NSA_LO_POS+1:NSA_LO_POS];
    wire out_take_w = dec_valid & dec_ready;
    assign fetch_ready = en_ff & (st_ff != S_DEC) & (st_ff != S_OUT);
    assign dec_valid   = (st_ff == S_OUT);
    assign dec_out     = dec_ff;

    // next state: dword 0, dword 1, then nsa extra dwords
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            S_DW0: if (take_w && enc_ok_w) nxt_st = S_DW1;
            S_DW1: if (take_w) begin
                // normal form ends here, scattered reads more
                nxt_st = (nsa_w == 2'h0) ? S_DEC : S_EXT;
            end
            S_EXT: if (take_w && (ext_idx_ff + 2'h1 == nsa_w)) begin
                nxt_st = S_DEC; // exact length consumed
            end
            S_DEC: nxt_st = S_OUT;
            S_OUT: if (out_take_w) nxt_st = S_DW0;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= S_DW0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // dword capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dw0_ff     <= 32'h0;
            dw1_ff     <= 32'h0;
            ext_ff     <= '0;
            ext_idx_ff <= 2'h0;
        end else if (take_w) begin
            if (st_ff == S_DW0) begin
                dw0_ff     <= fetch_dword;
                ext_idx_ff <= 2'h0;
            end
            if (st_ff == S_DW1) dw1_ff <= fetch_dword;
            if (st_ff == S_EXT) begin
                ext_ff[ext_idx_ff] <= fetch_dword;
                ext_idx_ff         <= ext_idx_ff + 2'h1;
            end
        end
    end

    // field extraction
    // bit 0 is the opcode's top bit, bits 24:18 its low seven
    wire [7:0] opc_w  = {dw0_ff[OP_LO_POS],
                         dw0_ff[OP_HI_LO_POS+6:OP_HI_LO_POS]};
    wire [3:0] dmask_w = dw0_ff[DMASK_LO_POS+3:DMASK_LO_POS];
    wire [7:0] addr_vreg_field_w = dw1_ff[ADDR_VREG_FIELD_LO_POS+7:ADDR_VREG_FIELD_LO_POS];
    wire [7:0] data_vreg_field_w = dw1_ff[DATA_VREG_FIELD_LO_POS+7:DATA_VREG_FIELD_LO_POS];
    wire       hdata_w = dw1_ff[HDATA_POS];
    wire       is_atomic_w = (opc_w >= OPC_ATOMIC_LO) &&
                             (opc_w <= OPC_ATOMIC_HI);

    // operation class
    imdec_op_t cls_w;
    assign cls_w = (opc_w == OPC_LOAD)      ? IMDEC_LOAD      :
                   (opc_w == OPC_LOAD_MIP)  ? IMDEC_LOAD_LVL  :
                   (opc_w == OPC_STORE)     ? IMDEC_STORE     :
                   (opc_w == OPC_STORE_MIP) ? IMDEC_STORE_LVL :
                   is_atomic_w              ? IMDEC_ATOMIC    : IMDEC_OTHER;
    wire is_store_w = (cls_w == IMDEC_STORE) || (cls_w == IMDEC_STORE_LVL);
    wire no_samp_w  = (cls_w != IMDEC_OTHER);

    // count of set bits in a four bit mask
    function automatic logic [2:0] pop4(input logic [3:0] m);
        pop4 = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
    endfunction
    wire [2:0] pop_w = pop4(dmask_w);

    // scalar fields and cache policy
    assign dec_w.op_class     = cls_w;
    assign dec_w.opcode       = opc_w;
    assign dec_w.length       = MIN_DWORDS + {1'b0, nsa_w};
    assign dec_w.nsa_cnt      = nsa_w;
    assign dec_w.dev_coh      = dw0_ff[DEVCOH_POS];
    assign dec_w.dmask        = dmask_w;
    assign dec_w.unnorm       = dw0_ff[UNNORMALIZED_ADDR_BIT_POS];
    assign dec_w.l0_bypass    = dw0_ff[GLC_POS] & ~is_atomic_w;
    assign dec_w.return_preop = dw0_ff[GLC_POS] & is_atomic_w;
    assign dec_w.small_rsrc   = dw0_ff[SMALL_POS];
    assign dec_w.rsrc_cnt     = dw0_ff[SMALL_POS] ? SMALL_RSRC_REGS
                                                  : LARGE_RSRC_REGS;
    assign dec_w.tex_fail_en  = dw0_ff[TFE_POS];
    assign dec_w.lod_warn_en  = dw0_ff[LWE_POS];
    assign dec_w.l2_policy    = {dw0_ff[SYSCOH_POS],
                                 dw0_ff[DEVCOH_POS]};
    assign dec_w.data_vreg    = data_vreg_field_w;
    // pointers gain two zero low bits, four aligned
    assign dec_w.rsrc_sreg    = {dw1_ff[RSRC_LO_POS+4:RSRC_LO_POS],
                                 2'h0};
    assign dec_w.samp_sreg    = {dw1_ff[SAMP_LO_POS+4:SAMP_LO_POS],
                                 2'h0};
    assign dec_w.half_addr    = dw1_ff[HADDR_POS];
    // unsigned without sampler, float with one
    assign dec_w.addr_float   = dw1_ff[HADDR_POS] & ~no_samp_w;
    assign dec_w.half_data    = hdata_w;
    // two half words share one register on half data stores
    assign dec_w.data_reg_cnt = (hdata_w && is_store_w) ?
                                3'((pop_w + 3'h1) >> 1) : pop_w;

    // per component data register mapping
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_comp
            localparam logic [3:0] BELOW = 4'((1 << gi) - 1);
            localparam logic [2:0] IDX   = 3'(gi);
            wire [2:0] rank_w = pop4(dmask_w & BELOW);
            wire       d16_w  = hdata_w & is_store_w;
            // enabled components take consecutive registers
            // half data: word gi is low then high half
            assign dec_w.comp_vreg[gi] = d16_w ?
                data_vreg_field_w + {7'h0, IDX[1]} : data_vreg_field_w + {5'h0, rank_w};
            assign dec_w.comp_half[gi] = d16_w & IDX[0];
            // stores fill missing components with zero
            assign dec_w.comp_zero[gi] = d16_w ? (IDX >= pop_w)
                                               : ~dmask_w[gi];
        end
    endgenerate

    // per slot address register mapping
    genvar ga;
    generate
        for (ga = 0; ga < ADDR_SLOTS; ga++) begin : g_addr
            if (ga == 0) begin : g_base
                assign dec_w.addr_vreg[ga] = addr_vreg_field_w;
            end else begin : g_rest
                localparam int DW = (ga - 1) / 4;
                localparam int BY = (ga - 1) % 4;
                localparam logic [1:0] DWN = 2'(DW);
                wire [7:0] sc_w = ext_ff[DW][BY*8+7:BY*8];
                // scattered slot, or contiguous run
                assign dec_w.addr_vreg[ga] =
                    (nsa_w == 2'h0) ? addr_vreg_field_w + 8'(ga) :
                    (DWN < nsa_w)   ? sc_w : 8'h0;
            end
        end
    endgenerate

    // decode register, loaded once all dwords are in
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_ff <= '0;
        end else if (st_ff == S_DEC) begin
            dec_ff <= dec_w;
        end
    end

    // ahb address phase decode
    wire       acc_w   = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire [3:0] off_w   = {haddr[3:2], 2'h0};
    wire       wr_st_w = wr_pend_ff & (wr_addr_ff == REG_STATUS);
    wire       wr_ct_w = wr_pend_ff & (wr_addr_ff == REG_CTRL);
    // store without unnormalized addressing is flagged
    wire unnormalized_addr_bit_ev_w = (st_ff == S_DEC) & (is_store_w | is_atomic_w) &
                     ~dw0_ff[UNNORMALIZED_ADDR_BIT_POS];
    wire benc_ev_w = take_w & (st_ff == S_DW0) & ~enc_ok_w;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ahb phase registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            wr_addr_ff <= 4'h0;
            rd_addr_ff <= 4'h0;
        end else if (hready) begin
            wr_pend_ff <= acc_w & hwrite;
            rd_pend_ff <= acc_w & ~hwrite;
            wr_addr_ff <= off_w;
            rd_addr_ff <= off_w;
        end
    end

    // control and sticky status, a new event wins over its clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff       <= CTRL_EN_RST;
            bad_enc_ff  <= 1'b0;
            unnormalized_addr_bit_err_ff <= 1'b0;
        end else begin
            if (wr_ct_w) en_ff <= hwdata[0];
            bad_enc_ff  <= benc_ev_w | (bad_enc_ff & ~(wr_st_w & hwdata[1]));
            unnormalized_addr_bit_err_ff <= unnormalized_addr_bit_ev_w | (unnormalized_addr_bit_err_ff & ~(wr_st_w & hwdata[2]));
        end
    end

    // decoded instruction counter, cleared by writing it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 16'h0;
        end else if (st_ff == S_DEC) begin
            count_ff <= count_ff + 16'h1;
        end else if (wr_pend_ff && (wr_addr_ff == REG_COUNT)) begin
            count_ff <= 16'h0;
        end
    end

    // read data mux, haddr bits 3:2 pick one of the four registers, higher offsets alias
    wire [31:0] rd_mux_w =
        (rd_addr_ff == REG_CTRL)   ? {31'h0, en_ff} :
        (rd_addr_ff == REG_STATUS) ? {29'h0, unnormalized_addr_bit_err_ff, bad_enc_ff,
                                      (st_ff != S_DW0)} :
        (rd_addr_ff == REG_COUNT)  ? {16'h0, count_ff} :
        (rd_addr_ff == REG_LAST)   ? {21'h0, dec_ff.length,
                                      dec_ff.opcode} : 32'h0;
    assign hrdata = rd_pend_ff ? rd_mux_w : 32'h0;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_len_range: assert property (dec_valid |-> (dec_out.length >= MIN_DWORDS)
        && (dec_out.length <= MAX_DWORDS))
        else $error("length out of range");
    a_len_nsa: assert property (dec_valid |->
        dec_out.length == 3'h2 + {1'b0, dec_out.nsa_cnt})
        else $error("length not two plus extra count");
    a_bad_encoding: assert property ((st_ff == S_DW0 && take_w && !enc_ok_w)
        |=> st_ff == S_DW0)
        else $error("foreign encoding was taken");
    a_exact_consume: assert property ((st_ff == S_EXT && take_w &&
        ext_idx_ff + 2'h1 == nsa_w) |=> !fetch_ready [*2])
        else $error("dword taken past instruction end");
    a_rsrc_count: assert property (dec_valid |-> dec_out.rsrc_cnt ==
        (dec_out.small_rsrc ? 4'h4 : 4'h8))
        else $error("resource register count wrong");
    a_sreg_align: assert property (dec_valid |-> dec_out.rsrc_sreg[1:0] == 2'h0
        && dec_out.samp_sreg[1:0] == 2'h0)
        else $error("scalar pointer not four aligned");
    a_addr_contig: assert property (dec_valid && dec_out.nsa_cnt == 2'h0 |->
        dec_out.addr_vreg[1] == dec_out.addr_vreg[0] + 8'h1)
        else $error("normal address run not contiguous");
    a_store_zero: assert property (dec_valid && !dec_out.half_data &&
        dec_out.op_class == IMDEC_STORE |->
        dec_out.comp_zero == ~dec_out.dmask)
        else $error("missing store component not zeroed");
    a_l2_policy: assert property (dec_valid |-> dec_out.l2_policy ==
        {dw0_ff[25], dw0_ff[7]})
        else $error("l2 policy bits wrong");
    a_out_hold: assert property (dec_valid && !dec_ready |=>
        dec_valid && $stable(dec_out))
        else $error("decode dropped before accepted");
    a_unnormalized_addr_bit_flag: assert property (unnormalized_addr_bit_ev_w |=> unnormalized_addr_bit_err_ff)
        else $error("missing unnormalized store not flagged");

    c_normal: cover property (dec_valid && dec_out.nsa_cnt == 2'h0);
    c_nsa_max: cover property (dec_valid && dec_out.nsa_cnt == 2'h3);
    c_bad_enc: cover property (benc_ev_w);
endmodule // imdec_top
`default_nettype wire

// file: imdec_fetch_model.sv
// fetch stage model handing instruction dwords to the decoder
`timescale 1ns/1ps
`default_nettype none
module imdec_fetch_model (
    // clock
    input  wire logic        sys_clk,
    // fetch link
    input  wire logic        fetch_ready,
    output logic      [31:0] fetch_dword,
    output logic             fetch_valid
);
    logic [31:0] last_dw; // last dword offered

    // link idle at time zero
    initial begin
        fetch_valid = 1'b0;
        fetch_dword = 32'h0;
        last_dw     = 32'h0;
    end

    // offer one dword, after an optional stall, hold until taken
    task automatic send(input logic [31:0] dw, input int gap);
        if (gap > 0) begin
            idle();
            repeat (gap) @(posedge sys_clk);
        end
        fetch_valid <= 1'b1;
        fetch_dword <= dw; // dwords go out in instruction order
        last_dw = dw;
        do @(posedge sys_clk); while (fetch_ready !== 1'b1);
    endtask

    // release the link, data line no longer shows the last dword
    task automatic idle();
        fetch_valid <= 1'b0;
        fetch_dword <= ~last_dw;
    endtask
endmodule // imdec_fetch_model
`default_nettype wire

// file: tb_imdec_top.sv
// self-checking testbench of the image memory instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_imdec_top;
    import imdec_pkg::*;
    // clock, reset, bus and link signals
    logic        sys_clk, rst_n, hsel, hwrite, dec_ready;
    logic        hreadyout, hresp, fetch_valid, fetch_ready, dec_valid;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, fetch_dword, r;
    imdec_dec_t  dec_out, d;
    int          errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0]  ops [4] = '{OPC_LOAD_MIP, OPC_STORE, OPC_ATOMIC_LO + 8'h01,
                             8'ha2};
    imdec_op_t   cls [4] = '{IMDEC_LOAD_LVL, IMDEC_STORE, IMDEC_ATOMIC,
                             IMDEC_OTHER};

    imdec_top imdec_top_i (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .fetch_dword, .fetch_valid, .fetch_ready, .dec_out, .dec_valid,
        .dec_ready);
    imdec_fetch_model imdec_fetch_model_i (.sys_clk, .fetch_ready,
        .fetch_dword, .fetch_valid);

    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            end_sim();
        end
    end

    // one comparison, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // single ahb-lite word transfer, waits on hready
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // read a register and compare
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(r, exp, "register");
    endtask

    // first dword: encoding, flags, mask, opcode split over bit 0 and 24:18
    function automatic logic [31:0] mk0(logic [7:0] op, logic [1:0] scattered_addr_dword_count,
        logic device_coherent_bit, logic [3:0] dm, logic un, logic global_coherent_bit, logic small_resource_bit,
        logic texture_fail_enable, logic lod_warning_enable, logic system_coherent_bit);
        return {IMG_ENCODING, system_coherent_bit, op[6:0], lod_warning_enable, texture_fail_enable, small_resource_bit, 1'b0, global_coherent_bit, un,
                dm, device_coherent_bit, 4'h0, scattered_addr_dword_count, op[7]};
    endfunction

    // second dword: register pointers and half width bits
    function automatic logic [31:0] mk1(logic [7:0] va, logic [7:0] vd,
        logic [4:0] rs, logic [4:0] sp, logic a16, logic d16);
        return {d16, a16, 4'h0, sp, rs, vd, va};
    endfunction

    // send a whole instruction then release the link
    task automatic instr(input logic [4:0][31:0] w, input int len,
                         input int gap);
        for (int i = 0; i < len; i++) imdec_fetch_model_i.send(w[i], gap);
        imdec_fetch_model_i.idle();
    endtask

    // wait for the decode, two edges after the last dword
    task automatic get_dec();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (n == 1) chk(fetch_ready, 32'h0, "refuse while busy");
        end while (dec_valid !== 1'b1 && n < 20);
        d = dec_out;
        chk(n, 32'h2, "decode latency");
    endtask

    // print counts and verdict, then stop
    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        dec_ready = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk(dec_valid, 32'h0, "reset valid");
        rd_chk(REG_CTRL, {31'h0, CTRL_EN_RST});
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(REG_COUNT, 32'h0);
        rd_chk(32'h10, 32'h1);
        // normal load, contiguous address registers
        instr({96'h0, mk1(8'h10, 8'h20, 5'h03, 5'h05, 1'b1, 1'b0),
               mk0(OPC_LOAD, 2'h0, 1, 4'h9, 0, 1, 1, 1, 0, 0)}, 2, 0);
        get_dec();
        chk({d.op_class, d.opcode, d.length}, {IMDEC_LOAD, 8'h0, 3'h2}, "op");
        chk({d.dev_coh, d.l0_bypass, d.return_preop, d.small_rsrc, d.tex_fail_en,
             d.lod_warn_en, d.half_addr, d.unnorm, d.half_data}, 9'h1b4, "flags");
        chk({d.l2_policy, d.rsrc_cnt, d.dmask}, {2'h1, 4'h4, 4'h9}, "policy");
        chk({d.data_vreg, d.rsrc_sreg, d.samp_sreg}, {8'h20, 7'h0c, 7'h14}, "ptrs");
        chk({d.comp_vreg[0], d.comp_vreg[3], d.comp_zero}, 20'h20216, "comps");
        for (int k = 0; k < 4; k++) chk(d.addr_vreg[k], 8'h10 + k, "addr");
        // scattered store with level, half data, slow partner, pipeline stall
        dec_ready <= 1'b0;
        instr({32'h1b1a1918, 32'h17161514, 32'h13121110,
               mk1(8'h40, 8'h50, 5'h1f, 5'h00, 1'b0, 1'b1),
               mk0(OPC_STORE_MIP, 2'h3, 0, 4'h7, 1, 0, 0, 0, 1, 1)}, 5, 2);
        get_dec();
        chk({d.op_class, d.opcode, d.length, d.nsa_cnt},
            {IMDEC_STORE_LVL, 8'h09, 3'h5, 2'h3}, "op");
        chk({d.dev_coh, d.l0_bypass, d.return_preop, d.small_rsrc, d.tex_fail_en,
             d.lod_warn_en, d.half_addr, d.unnorm, d.half_data}, 9'h00b, "flags");
        chk({d.l2_policy, d.rsrc_cnt, d.rsrc_sreg}, {2'h2, 4'h8, 7'h7c}, "rsrc");
        chk({d.data_reg_cnt, d.comp_half, d.comp_zero}, 11'h2a8, "half");
        chk({d.comp_vreg[1], d.comp_vreg[2]}, 16'h5051, "half regs");
        chk(d.addr_vreg[0], 8'h40, "base");
        for (int k = 1; k < 13; k++) chk(d.addr_vreg[k], 8'h0f + k, "nsa");
        repeat (3) begin
            @(posedge sys_clk);
            chk({dec_valid, (dec_out === d)}, 2'h3, "hold");
        end
        dec_ready <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(dec_valid, 32'h0, "released");
        // opcode classes, masked stores zero fill, atomics return old value
        for (int i = 0; i < 4; i++) begin
            instr({96'h0, mk1(8'h00, 8'h30, 5'h0, 5'h0, 1'b1, 1'b0),
                   mk0(ops[i], 2'h0, 0, 4'h5, 0, 1, 0, 0, 0, 0)}, 2, 0);
            get_dec();
            chk({d.op_class, d.opcode}, {cls[i], ops[i]}, "class");
            chk({d.l0_bypass, d.return_preop, d.addr_float},
                {i != 2, i == 2, i == 3}, "glc");
            chk({d.comp_zero, d.comp_vreg[2], d.data_reg_cnt}, 15'h518a, "mask");
        end
        rd_chk(REG_STATUS, 32'h4);
        ahb(1'b1, REG_STATUS, 32'h4);
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(REG_LAST, 32'h2a2);
        rd_chk(REG_COUNT, 32'h6);
        // foreign encoding is consumed and flagged
        imdec_fetch_model_i.send(32'h0, 0);
        imdec_fetch_model_i.idle();
        rd_chk(REG_STATUS, 32'h2);
        ahb(1'b1, REG_COUNT, 32'h1);
        rd_chk(REG_COUNT, 32'h0);
        // disabled decoder refuses dwords
        ahb(1'b1, REG_CTRL, 32'h0);
        @(posedge sys_clk);
        chk(fetch_ready, 32'h0, "disabled");
        ahb(1'b1, REG_CTRL, 32'h1);
        @(posedge sys_clk);
        chk(fetch_ready, 32'h1, "enabled");
        end_sim();
    end
endmodule // tb_imdec_top
`default_nettype wire
